// [hw/seg_display_pkg.sv]
package seg_display_pkg;
  // SFR offsets
  localparam logic [7:0] ADDR_DISPLAY_CONFIG = 8'h95;
  localparam logic [7:0] ADDR_SEGMENT_ENABLE_LOW = 8'h97;
  localparam logic [7:0] ADDR_DISPLAY_CONFIG_EXTENDED = 8'h9c;
  localparam logic [7:0] ADDR_SEGMENT_MEMORY_POINTER = 8'hac;
  localparam logic [7:0] ADDR_SEGMENT_MEMORY_DATA = 8'hae;
  localparam logic [7:0] ADDR_DISPLAY_UPDATE_HOLD = 8'hb1;
  localparam logic [7:0] ADDR_SEGMENT_ENABLE_HIGH = 8'hed;
  // Memory geometry
  localparam int MEM_DEPTH = 15;
  localparam logic [5:0] MEM_LAST_ADDR = 6'h0e;
  localparam int SEG_LINES = 29;
  localparam int COM_LINES = 4;
  // Field positions
  localparam int PTR_WRITE_BIT = 7;
  localparam int PTR_RSVD_BIT = 6;
  localparam int CFG_DISPLAY_ENABLE_BIT = 7;
  localparam int CFG_MEMORY_CLEAR_BIT = 6;
  localparam int CFG_POWERSAVE_DISABLE_BIT = 5;
  localparam int CFG_MUX_LSB = 0;
  localparam int CFGX_SOURCE_SELECT_BIT = 7;
  localparam int HOLD_BIT = 0;
  localparam logic [1:0] MUX_3WAY = 2'h2;
  localparam logic [1:0] MUX_4WAY = 2'h3;
  // Reset value and write masks
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] SEGE_HIGH_MASK = 8'h0f;
  localparam logic [7:0] SEGE_LOW_MASK = 8'hfc;
  localparam logic [7:0] PTR_MASK = 8'hbf;
endpackage

// [hw/seg_line_map.sv]
`timescale 1ns/10ps
`default_nettype none
// Turns the shown memory image into per-line drive patterns
module seg_line_map (
  input wire logic [8*seg_display_pkg::MEM_DEPTH-1:0] image_i,
  input wire logic [28:0] line_en_i,
  output logic [4*seg_display_pkg::SEG_LINES-1:0] pattern_o
);
  genvar g;
  generate
    for (g = 0; g < seg_display_pkg::SEG_LINES; g++) begin : g_line
      // Even line low nibble, odd line high nibble
      assign pattern_o[4*g +: 4] = line_en_i[g] ? image_i[8*(g/2) + 4*(g%2) +: 4] : 4'h0;
    end
  endgenerate
endmodule
`default_nettype wire

// [hw/seg_display_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module seg_display_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic deep_powersave_mode_i,
  output logic [7:0] sfr_rdata_o,
  output logic [4*seg_display_pkg::SEG_LINES-1:0] segment_line_o,
  output logic [28:0] segment_line_active_o,
  output logic [1:0] common_line_extra_o,
  output logic display_on_o,
  output logic pump_enable_o,
  output logic ladder_select_o,
  output logic [5:0] bias_level_o
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] mem_q [seg_display_pkg::MEM_DEPTH];
  logic [7:0] mem_d [seg_display_pkg::MEM_DEPTH];
  logic [7:0] cfg_q, cfg_d, cfgx_q, cfgx_d, ptr_q, ptr_d, dat_q, dat_d;
  logic [7:0] sege_lo_q, sege_lo_d, sege_hi_q, sege_hi_d, hold_q, hold_d;
  logic [7:0] rdata_q, rdata_d;
  logic [5:0] ptr_addr;
  logic in_range;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign ptr_addr = sfr_wdata_i[5:0];
  assign in_range = (ptr_addr <= seg_display_pkg::MEM_LAST_ADDR);

  always_comb begin
    cfg_d = cfg_q;
    cfgx_d = cfgx_q;
    ptr_d = ptr_q;
    dat_d = dat_q;
    sege_lo_d = sege_lo_q;
    sege_hi_d = sege_hi_q;
    hold_d = hold_q;
    for (int i = 0; i < seg_display_pkg::MEM_DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (sfr_wr_i) begin
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_DISPLAY_CONFIG)) begin
        cfg_d = sfr_wdata_i;
        cfg_d[seg_display_pkg::CFG_MEMORY_CLEAR_BIT] = 1'b0;
      end
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_DISPLAY_CONFIG_EXTENDED)) begin
        cfgx_d = sfr_wdata_i;
      end
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_SEGMENT_ENABLE_LOW)) begin
        sege_lo_d = sfr_wdata_i & seg_display_pkg::SEGE_LOW_MASK;
      end
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_SEGMENT_ENABLE_HIGH)) begin
        sege_hi_d = sfr_wdata_i & seg_display_pkg::SEGE_HIGH_MASK;
      end
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_DISPLAY_UPDATE_HOLD)) begin
        hold_d = sfr_wdata_i;
      end
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_SEGMENT_MEMORY_DATA)) begin
        dat_d = sfr_wdata_i;
      end
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_SEGMENT_MEMORY_POINTER)) begin
        ptr_d = sfr_wdata_i & seg_display_pkg::PTR_MASK;
        if (in_range) begin
          if (sfr_wdata_i[seg_display_pkg::PTR_WRITE_BIT]) begin
            mem_d[ptr_addr[3:0]] = dat_q;
          end else begin
            dat_d = mem_q[ptr_addr[3:0]];
          end
        end else if (!sfr_wdata_i[seg_display_pkg::PTR_WRITE_BIT]) begin
          dat_d = seg_display_pkg::RST_BYTE;
        end
      end
      // Clear wins over a pointer store in the same write cycle
      if (hit(sfr_addr_i, seg_display_pkg::ADDR_DISPLAY_CONFIG) &&
          sfr_wdata_i[seg_display_pkg::CFG_MEMORY_CLEAR_BIT]) begin
        for (int i = 0; i < seg_display_pkg::MEM_DEPTH; i++) begin
          mem_d[i] = seg_display_pkg::RST_BYTE;
        end
      end
    end
    // The top nibble of the last byte has no line behind it
    mem_d[seg_display_pkg::MEM_DEPTH-1][7:4] = 4'h0;
  end

  always_comb begin
    rdata_d = seg_display_pkg::RST_BYTE;
    unique case (sfr_addr_i)
      seg_display_pkg::ADDR_DISPLAY_CONFIG: rdata_d = cfg_q;
      seg_display_pkg::ADDR_SEGMENT_ENABLE_LOW: rdata_d = sege_lo_q;
      seg_display_pkg::ADDR_DISPLAY_CONFIG_EXTENDED: rdata_d = cfgx_q;
      seg_display_pkg::ADDR_SEGMENT_MEMORY_POINTER: rdata_d = ptr_q;
      seg_display_pkg::ADDR_SEGMENT_MEMORY_DATA: rdata_d = dat_q;
      seg_display_pkg::ADDR_DISPLAY_UPDATE_HOLD: rdata_d = hold_q;
      seg_display_pkg::ADDR_SEGMENT_ENABLE_HIGH: rdata_d = sege_hi_q;
      default: rdata_d = seg_display_pkg::RST_BYTE;
    endcase
    if (!sfr_rd_i) begin
      rdata_d = rdata_q;
    end
  end

  // Memory clears on reset too; no separate power-on path exists here
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < seg_display_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= seg_display_pkg::RST_BYTE;
      end
      cfg_q <= seg_display_pkg::RST_BYTE;
      cfgx_q <= seg_display_pkg::RST_BYTE;
      ptr_q <= seg_display_pkg::RST_BYTE;
      dat_q <= seg_display_pkg::RST_BYTE;
      sege_lo_q <= seg_display_pkg::RST_BYTE;
      sege_hi_q <= seg_display_pkg::RST_BYTE;
      hold_q <= seg_display_pkg::RST_BYTE;
      rdata_q <= seg_display_pkg::RST_BYTE;
    end else begin
      for (int i = 0; i < seg_display_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
      cfg_q <= cfg_d;
      cfgx_q <= cfgx_d;
      ptr_q <= ptr_d;
      dat_q <= dat_d;
      sege_lo_q <= sege_lo_d;
      sege_hi_q <= sege_hi_d;
      hold_q <= hold_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Display side
  // ----------------------------------------------------------------
  logic [8*seg_display_pkg::MEM_DEPTH-1:0] shown_q, shown_d;
  logic [28:0] line_en;
  logic [4*seg_display_pkg::SEG_LINES-1:0] pattern;
  logic disp_on, four_way, com2_on;
  logic [28:0] active_q;
  logic [4*seg_display_pkg::SEG_LINES-1:0] seg_q;
  logic [1:0] com_extra_q;
  logic on_q, pump_q, ladder_q;
  logic [5:0] bias_q;

  // Freeze the glass image while software holds it
  always_comb begin
    shown_d = shown_q;
    if (!hold_q[seg_display_pkg::HOLD_BIT]) begin
      for (int i = 0; i < seg_display_pkg::MEM_DEPTH; i++) begin
        shown_d[8*i +: 8] = mem_q[i];
      end
    end
  end

  assign four_way = (cfg_q[seg_display_pkg::CFG_MUX_LSB +: 2] == seg_display_pkg::MUX_4WAY);
  assign com2_on = four_way ||
    (cfg_q[seg_display_pkg::CFG_MUX_LSB +: 2] == seg_display_pkg::MUX_3WAY);
  // Only the display enable bit and the powersave bit with deep_powersave_mode_i gate; the retained registers are untouched when off
  assign disp_on = cfg_q[seg_display_pkg::CFG_DISPLAY_ENABLE_BIT] &&
    !(deep_powersave_mode_i && cfg_q[seg_display_pkg::CFG_POWERSAVE_DISABLE_BIT]);

  always_comb begin
    line_en = '0;
    line_en[15:0] = 16'hffff;
    line_en[21:16] = {sege_lo_q[3:2], sege_hi_q[3:0]};
    line_en[25:22] = sege_lo_q[7:4];
    line_en[26] = 1'b1;
    line_en[27] = !four_way;
    line_en[28] = !com2_on;
  end

  seg_line_map u_map (
    .image_i(shown_q),
    .line_en_i(line_en),
    .pattern_o(pattern)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shown_q <= '0;
      seg_q <= '0;
      active_q <= '0;
      com_extra_q <= 2'h0;
      on_q <= 1'b0;
      pump_q <= 1'b0;
      ladder_q <= 1'b0;
      bias_q <= 6'h00;
    end else begin
      shown_q <= shown_d;
      seg_q <= disp_on ? pattern : '0;
      active_q <= line_en;
      com_extra_q <= {four_way, com2_on};
      on_q <= disp_on;
      ladder_q <= cfgx_q[seg_display_pkg::CFGX_SOURCE_SELECT_BIT];
      pump_q <= disp_on && !cfgx_q[seg_display_pkg::CFGX_SOURCE_SELECT_BIT];
      bias_q <= cfgx_q[seg_display_pkg::CFGX_SOURCE_SELECT_BIT] ? 6'h00 : cfgx_q[5:0];
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign segment_line_o = seg_q;
  assign segment_line_active_o = active_q;
  assign common_line_extra_o = com_extra_q;
  assign display_on_o = on_q;
  assign pump_enable_o = pump_q;
  assign ladder_select_o = ladder_q;
  assign bias_level_o = bias_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_read_loads;
    @(posedge clk_i) disable iff (sys_rst_i)
    sfr_wr_i && sfr_addr_i == seg_display_pkg::ADDR_SEGMENT_MEMORY_POINTER &&
      !sfr_wdata_i[7] && sfr_wdata_i[5:0] <= 6'h0e
      |=> dat_q == $past(mem_q[sfr_wdata_i[3:0]]);
  endproperty
  a_read_loads: assert property (p_read_loads) else $error("read did not load data");

  property p_write_stores;
    @(posedge clk_i) disable iff (sys_rst_i)
    sfr_wr_i && sfr_addr_i == seg_display_pkg::ADDR_SEGMENT_MEMORY_POINTER &&
      sfr_wdata_i[7] && sfr_wdata_i[5:0] < 6'h0e
      |=> mem_q[$past(sfr_wdata_i[3:0])] == $past(dat_q);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write did not store");

  property p_top_nibble;
    @(posedge clk_i) disable iff (sys_rst_i)
    mem_q[14][7:4] == 4'h0;
  endproperty
  a_top_nibble: assert property (p_top_nibble) else $error("last byte upper nibble set");

  property p_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
    sfr_wr_i && sfr_addr_i == seg_display_pkg::ADDR_DISPLAY_CONFIG && sfr_wdata_i[6]
      |=> mem_q[0] == 8'h00 && mem_q[7] == 8'h00 && mem_q[14] == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("memory clear failed");

  property p_pump_off;
    @(posedge clk_i) disable iff (sys_rst_i)
    !cfg_q[7] ##1 !cfg_q[7] |-> !pump_enable_o;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump on while disabled");

  property p_ladder_bias;
    @(posedge clk_i) disable iff (sys_rst_i)
    cfgx_q[7] |=> ladder_select_o && bias_level_o == 6'h00;
  endproperty
  a_ladder_bias: assert property (p_ladder_bias) else $error("bias used with ladder");

  property p_psm;
    @(posedge clk_i) disable iff (sys_rst_i)
    deep_powersave_mode_i && cfg_q[5] |=> !display_on_o;
  endproperty
  a_psm: assert property (p_psm) else $error("display on in powersave");

  property p_four_way;
    @(posedge clk_i) disable iff (sys_rst_i)
    cfg_q[1:0] == 2'h3 |=> segment_line_o[4*27 +: 8] == 8'h00;
  endproperty
  a_four_way: assert property (p_four_way) else $error("shared pins drive segments");

  property p_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    hold_q[0] |=> $stable(shown_q);
  endproperty
  a_hold: assert property (p_hold) else $error("image changed during hold");
endmodule
`default_nettype wire

// [test/glass_panel_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Glass panel: latches what the pins drive
// ----------------------------------------
// Raw image, no masking, so a driven inactive line stays visible
module glass_panel_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [4*seg_display_pkg::SEG_LINES-1:0] segment_line_i,
  output logic [4*seg_display_pkg::SEG_LINES-1:0] shown_o
);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shown_o <= '0;
    end else begin
      shown_o <= segment_line_i;
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic deep_powersave_mode_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic [115:0] seg_lines;
  logic [115:0] shown;
  logic [28:0] line_active;
  logic [1:0] com_extra;
  logic disp_on;
  logic pump_en;
  logic ladder;
  logic [5:0] bias;
  logic [7:0] mem [15];
  logic [9:0] sege;
  logic [7:0] tmp;
  logic [55:0] reg_list = {8'h95, 8'h97, 8'h9c, 8'hac, 8'hae, 8'hb1, 8'hed};
  time wr_end = 0;
  int n_fail = 0;
  int n_checks = 0;
  always #20 clk_i = ~clk_i;
  seg_display_ctrl i_seg_display_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .deep_powersave_mode_i(deep_powersave_mode_i),
    .sfr_rdata_o(sfr_rdata_o), .segment_line_o(seg_lines),
    .segment_line_active_o(line_active), .common_line_extra_o(com_extra),
    .display_on_o(disp_on), .pump_enable_o(pump_en), .ladder_select_o(ladder),
    .bias_level_o(bias));
  glass_panel_model i_glass_panel_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .segment_line_i(seg_lines), .shown_o(shown));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Called at a falling edge; returns one falling edge after raising the strobe, with the strobe low
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // Back to back writes let one edge pass so the strobe never toggles twice in a step
    if (wr_end == $time) @(negedge clk_i);
    sfr_wr_i = 1'b1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
    wr_end = $time;
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_rd_i = 1'b1;
    sfr_addr_i = a;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic put(input int n, input logic [7:0] d);
    wr(8'hae, d);
    wr(8'hac, 8'h80 | n[7:0]);
    // The last byte keeps no upper nibble
    mem[n] = (n == 14) ? {4'h0, d[3:0]} : d;
  endtask
  // Pointer load followed at once by the data read
  task automatic get_all();
    for (int n = 0; n < 15; n++) begin
      wr(8'hac, n[7:0]);
      rd(8'hae);
      check(sfr_rdata_o, mem[n]);
    end
  endtask
  task automatic glass(input bit on, input bit mux4);
    logic [115:0] es;
    logic [28:0] ea;
    logic [7:0] b;
    es = '0;
    ea = '0;
    repeat (4) @(negedge clk_i);
    for (int l = 0; l < 29; l++) begin
      b = mem[l/2];
      ea[l] = (l < 16 || l > 25 || sege[l-16]) && !(mux4 && l > 26);
      if (on && ea[l]) es[4*l+:4] = l[0] ? b[7:4] : b[3:0];
    end
    check(shown, es);
    check(line_active, ea);
    check(disp_on, on);
    check(pump_en, on);
    check(com_extra, {mux4, mux4});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tmp = 8'($urandom(32'h89b9));
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (mem[n]) mem[n] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      tmp = (i < 7) ? reg_list[8*(6-i)+:8] : 8'h80;
      rd(tmp);
      check(sfr_rdata_o, 8'h00);
    end
    check(ladder, 1'b0);
    check({disp_on, pump_en, com_extra, bias}, 10'h000);
    $display("test reset done");
    for (int n = 0; n < 15; n++) put(n, 8'($urandom()));
    get_all();
    $display("test memory done");
    sege = 10'($urandom());
    wr(8'h97, {sege[9:4], 2'b00});
    wr(8'hed, {4'h0, sege[3:0]});
    rd(8'h97);
    check(sfr_rdata_o, {sege[9:4], 2'b00});
    wr(8'h95, 8'h80);
    glass(1'b1, 1'b0);
    wr(8'h95, 8'h83);
    glass(1'b1, 1'b1);
    // Three-way mux: only line 28 turns into a common
    wr(8'h95, 8'h82);
    repeat (4) @(negedge clk_i);
    check(com_extra, 2'h1);
    check(shown[115:108], {4'h0, mem[13][7:4]});
    $display("test mapping done");
    wr(8'h9c, 8'h2e);
    @(negedge clk_i);
    check({ladder, bias}, 7'h2e);
    wr(8'h9c, 8'hae);
    @(negedge clk_i);
    check({ladder, bias}, 7'h40);
    wr(8'h9c, 8'h2e);
    wr(8'h95, 8'h00);
    glass(1'b0, 1'b0);
    wr(8'h95, 8'h83);
    glass(1'b1, 1'b1);
    rd(8'h9c);
    check(sfr_rdata_o, 8'h2e);
    $display("test source done");
    // Freeze the glass while byte 0 changes, then release it
    wr(8'hb1, 8'h01);
    tmp = mem[0];
    put(0, ~tmp);
    mem[0] = tmp;
    glass(1'b1, 1'b1);
    mem[0] = ~tmp;
    wr(8'hb1, 8'h00);
    glass(1'b1, 1'b1);
    $display("test hold done");
    // Reference enable lives outside this block and is taken as set
    deep_powersave_mode_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'h95, {k[0], 1'b0, k[1], 5'h03});
      glass(k[0] && !k[1], 1'b1);
    end
    deep_powersave_mode_i = 1'b0;
    $display("test powersave done");
    wr(8'h95, 8'h40);
    foreach (mem[n]) mem[n] = 8'h00;
    @(negedge clk_i);
    get_all();
    $display("test clear done");
    end_sim();
  end
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
